// ===== rfb_buffer.sv
// Data buffer, transmit length counters, cause flags and parallel host port
`timescale 1ns/1ns
`default_nettype none
module rfb_buffer (
  input wire logic clk, // System clock, 50 MHz
  input wire logic rst_n, // Asynchronous reset, active low
  input wire logic port_clk, // Host data strobe clock
  input wire logic [7:0] ad_in, // Parallel bus level seen at the pins
  output logic [7:0] ad_out, // Parallel bus read data
  output logic ad_oe, // Parallel bus drive enable, high while driving
  output logic irq, // Interrupt request to the host, active high
  input wire logic air_tx_pop, // Framing engine takes the next byte
  output logic [7:0] air_tx_data, // Byte handed to the framing engine
  output logic air_tx_valid, // Pulse: air_tx_data is new
  output logic air_tx_active, // Transmission in progress
  output logic air_tx_eof, // Pulse: last byte handed over, send end-of-frame
  output logic [3:0] air_tx_broken, // Bits in the final broken byte
  input wire logic air_rx_sof, // Pulse: start-of-frame detected
  input wire logic air_rx_push, // Pulse: received byte on air_rx_data
  input wire logic [7:0] air_rx_data, // Received byte
  input wire logic air_rx_end, // Pulse: reception finished
  input wire logic air_rx_frame_err, // Pulse: framing fault
  input wire logic air_rx_crc_err, // Pulse: CRC fault
  input wire logic direct_mode_enter, // Pulse: enter raw front-end mode
  output logic direct_mode // Raw front-end mode active
);
  // Link side: one byte captured per strobe, announced by a toggle
  logic [7:0] link_word;
  logic link_toggle;
  logic [7:0] next_link_word;
  logic next_link_toggle;

  always_comb begin
    next_link_word = ad_in;
    next_link_toggle = ~link_toggle;
  end

  always_ff @(posedge port_clk or negedge rst_n) begin
    if (!rst_n) begin
      link_word <= 8'h00;
      link_toggle <= 1'b0;
    end else begin
      link_word <= next_link_word;
      link_toggle <= next_link_toggle;
    end
  end

  logic [2:0] sync_q;
  rfb_sync #(.WIDTH(3)) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d({link_toggle, ad_in[7], port_clk}),
    .q(sync_q)
  );

  // System side state
  rfb_pkg::rfb_port_state_t state, next_state;
  logic [4:0] addr, next_addr;
  logic rd, next_rd;
  logic cont, next_cont;
  localparam int FIFO_SLOTS = rfb_pkg::FIFO_DEPTH;
  logic [7:0] mem [FIFO_SLOTS];
  logic [7:0] next_mem [FIFO_SLOTS];
  logic [3:0] wr_ptr, next_wr_ptr;
  logic [3:0] rd_ptr, next_rd_ptr;
  logic [3:0] count, next_count;
  logic overflow, next_overflow;
  logic [7:0] irq_flags, next_irq_flags;
  logic next_irq;
  logic clear_on_stop, next_clear_on_stop;
  logic [7:0] tx_len_high, next_tx_len_high;
  logic [7:0] tx_len_low, next_tx_len_low;
  logic next_air_tx_active;
  logic [12:0] tx_sent, next_tx_sent;
  logic tx_long, next_tx_long;
  logic rx_active, next_rx_active;
  logic next_direct_mode;
  logic [7:0] next_ad_out;
  logic next_ad_oe;
  logic [7:0] next_air_tx_data;
  logic next_air_tx_valid;
  logic next_air_tx_eof;
  logic p_d7, p_tog, cont_arm;
  logic next_cont_arm;

  // Edge and delimiter decode on synchronised pins
  logic s_clk, s_d7, s_tog;
  logic start_cond, simple_stop, continuous_stop, byte_strobe;
  assign s_clk = sync_q[0];
  assign s_d7 = sync_q[1];
  assign s_tog = sync_q[2];
  // Our own read data moves line 7 while the strobe is high; it must not pose as a delimiter
  assign start_cond = s_d7 & ~p_d7 & s_clk & ~ad_oe;
  assign simple_stop = ~s_d7 & p_d7 & s_clk & ~ad_oe;
  assign continuous_stop = ~s_d7 & p_d7 & ~s_clk & cont_arm;
  assign byte_strobe = s_tog ^ p_tog;

  logic [12:0] tx_total;
  logic [12:0] tx_remain;
  logic [7:0] fill_state;
  assign tx_total = {1'b0, tx_len_high, tx_len_low[7:4]} + {12'h000, |tx_len_low[3:0]};
  assign tx_remain = tx_total - tx_sent;
  assign fill_state = {1'b0,
                       count >= rfb_pkg::FIFO_HIGH_COUNT,
                       air_tx_active && tx_remain == rfb_pkg::TX_LOW_REMAIN,
                       overflow,
                       count - 4'h1};

  function automatic logic [3:0] ptr_inc(input logic [3:0] p);
    ptr_inc = (p == rfb_pkg::FIFO_LAST_PTR) ? 4'h0 : p + 4'h1;
  endfunction

  function automatic logic [4:0] addr_step(input logic [4:0] a);
    // The data port keeps its address so long bursts stay on the buffer
    addr_step = (a == rfb_pkg::ADDR_DATA_PORT) ? a : a + 5'h01;
  endfunction

  rfb_pkg::rfb_host_word_t host_word;
  logic fifo_clear, push_host, pop_host, push_ok, pop_ok, pop_tx;
  logic [4:0] rd_addr;
  logic rd_present;

  always_comb begin
    host_word = rfb_pkg::rfb_host_word_t'(link_word);
    next_state = state;
    next_addr = addr;
    next_rd = rd;
    next_cont = cont;
    next_mem = mem;
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count = count;
    next_overflow = overflow;
    next_irq_flags = irq_flags;
    next_irq = irq;
    next_clear_on_stop = clear_on_stop;
    next_tx_len_high = tx_len_high;
    next_tx_len_low = tx_len_low;
    next_air_tx_active = air_tx_active;
    next_tx_sent = tx_sent;
    next_tx_long = tx_long;
    next_rx_active = rx_active;
    next_direct_mode = direct_mode | direct_mode_enter;
    next_ad_out = ad_out;
    next_ad_oe = ad_oe;
    next_air_tx_data = air_tx_data;
    next_air_tx_valid = 1'b0;
    next_air_tx_eof = 1'b0;
    next_cont_arm = s_clk ? 1'b0 : (cont_arm | (s_d7 & ~p_d7));
    fifo_clear = 1'b0;
    push_host = 1'b0;
    pop_host = 1'b0;
    rd_addr = addr;
    rd_present = 1'b0;

    // Host port sequencing
    if (start_cond) begin
      next_state = rfb_pkg::RFB_ADDR;
      next_ad_oe = 1'b0;
    end else if (simple_stop || continuous_stop) begin
      next_state = rfb_pkg::RFB_IDLE;
      next_ad_oe = 1'b0;
      next_cont_arm = 1'b0;
      if (simple_stop) begin
        next_direct_mode = 1'b0;
      end
      // Cause flags read in this transaction clear once it ends
      if (clear_on_stop) begin
        next_irq_flags = rfb_pkg::IRQ_CAUSE_RESET;
        next_irq = 1'b0;
        next_clear_on_stop = 1'b0;
      end
    end else if (byte_strobe) begin
      unique case (state)
        rfb_pkg::RFB_IDLE: begin
          next_state = rfb_pkg::RFB_IDLE;
        end
        rfb_pkg::RFB_ADDR: begin
          if (host_word.cmd) begin
            if (host_word.code == rfb_pkg::CMD_FIFO_RESET) begin
              fifo_clear = 1'b1;
            end
          end else begin
            next_addr = host_word.code;
            next_rd = host_word.rd;
            next_cont = host_word.cont;
            next_state = rfb_pkg::RFB_DATA;
            if (host_word.rd) begin
              rd_addr = host_word.code;
              rd_present = 1'b1;
            end
          end
        end
        rfb_pkg::RFB_DATA: begin
          if (rd) begin
            if (cont) begin
              rd_addr = addr_step(addr);
              next_addr = rd_addr;
              rd_present = 1'b1;
            end else begin
              next_state = rfb_pkg::RFB_ADDR;
              next_ad_oe = 1'b0;
            end
          end else begin
            unique case (addr)
              rfb_pkg::ADDR_TXLEN_HIGH: next_tx_len_high = link_word;
              rfb_pkg::ADDR_TXLEN_LOW: next_tx_len_low = link_word;
              rfb_pkg::ADDR_DATA_PORT: push_host = 1'b1;
              default: next_tx_len_low = tx_len_low;
            endcase
            if (cont) begin
              next_addr = addr_step(addr);
            end else begin
              next_state = rfb_pkg::RFB_ADDR;
            end
          end
        end
        default: next_state = rfb_pkg::RFB_IDLE;
      endcase
    end

    // Read data is driven from the strobe that selects it
    if (rd_present) begin
      next_ad_oe = 1'b1;
      unique case (rd_addr)
        rfb_pkg::ADDR_IRQ_CAUSE: begin
          next_ad_out = irq_flags;
          next_clear_on_stop = 1'b1;
        end
        rfb_pkg::ADDR_FILL_STATE: next_ad_out = fill_state;
        rfb_pkg::ADDR_TXLEN_HIGH: next_ad_out = tx_len_high;
        rfb_pkg::ADDR_TXLEN_LOW: next_ad_out = tx_len_low;
        rfb_pkg::ADDR_DATA_PORT: begin
          next_ad_out = mem[rd_ptr];
          pop_host = count != 4'h0;
        end
        default: next_ad_out = rfb_pkg::PORT_OUT_RESET;
      endcase
    end

    // Buffer movement; a host read wins the head over the air side
    pop_tx = air_tx_pop && air_tx_active && count != 4'h0 && !pop_host;
    pop_ok = pop_host | pop_tx;
    push_ok = (push_host | (air_rx_push & rx_active)) && count != rfb_pkg::FIFO_FULL_COUNT;
    if (fifo_clear) begin
      next_wr_ptr = 4'h0;
      next_rd_ptr = 4'h0;
      next_count = 4'h0;
      next_overflow = 1'b0;
      next_air_tx_active = 1'b0;
      next_tx_sent = 13'h0000;
    end else begin
      if ((push_host | (air_rx_push & rx_active)) && !push_ok) begin
        next_overflow = 1'b1;
      end
      if (push_ok) begin
        next_mem[wr_ptr] = push_host ? link_word : air_rx_data;
        next_wr_ptr = ptr_inc(wr_ptr);
      end
      if (pop_ok) begin
        next_rd_ptr = ptr_inc(rd_ptr);
      end
      next_count = count + {3'h0, push_ok} - {3'h0, pop_ok};
    end

    // Transmit side
    if (push_host && push_ok && !air_tx_active && !rx_active && tx_total != 13'h0000) begin
      next_air_tx_active = 1'b1;
      next_irq_flags[rfb_pkg::IRQ_TX_BIT] = 1'b1;
      next_tx_sent = 13'h0000;
      next_tx_long = tx_total >= rfb_pkg::TX_LONG_MIN;
    end
    if (pop_tx) begin
      next_air_tx_data = mem[rd_ptr];
      next_air_tx_valid = 1'b1;
      next_tx_sent = tx_sent + 13'h0001;
      if (tx_sent + 13'h0001 == tx_total) begin
        next_air_tx_eof = 1'b1;
        next_air_tx_active = 1'b0;
        next_irq = 1'b1;
      end else if (tx_long && count - 4'h1 == rfb_pkg::FIFO_REFILL_COUNT) begin
        next_irq = 1'b1;
      end
    end

    // Receive side; events are applied last so a set beats a clear
    if (air_rx_sof) begin
      next_rx_active = 1'b1;
      next_irq_flags[rfb_pkg::IRQ_SOF_BIT] = 1'b1;
    end
    if (air_rx_push && rx_active && push_ok && !push_host &&
        count + 4'h1 == rfb_pkg::FIFO_HIGH_COUNT) begin
      next_irq_flags[rfb_pkg::IRQ_LEVEL_BIT] = 1'b1;
      next_irq = 1'b1;
    end
    if (air_rx_frame_err) begin
      next_irq_flags[rfb_pkg::IRQ_FRAME_BIT] = 1'b1;
    end
    if (air_rx_crc_err) begin
      next_irq_flags[rfb_pkg::IRQ_CRC_BIT] = 1'b1;
    end
    if (air_rx_end && rx_active) begin
      next_rx_active = 1'b0;
      next_irq = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= rfb_pkg::RFB_IDLE;
      addr <= 5'h00;
      rd <= 1'b0;
      cont <= 1'b0;
      for (int i = 0; i < FIFO_SLOTS; i++) begin
        mem[i] <= 8'h00;
      end
      wr_ptr <= 4'h0;
      rd_ptr <= 4'h0;
      count <= 4'h0;
      overflow <= 1'b0;
      irq_flags <= rfb_pkg::IRQ_CAUSE_RESET;
      irq <= 1'b0;
      clear_on_stop <= 1'b0;
      tx_len_high <= rfb_pkg::TXLEN_RESET;
      tx_len_low <= rfb_pkg::TXLEN_RESET;
      air_tx_active <= 1'b0;
      tx_sent <= 13'h0000;
      tx_long <= 1'b0;
      rx_active <= 1'b0;
      direct_mode <= 1'b0;
      ad_out <= rfb_pkg::PORT_OUT_RESET;
      ad_oe <= 1'b0;
      air_tx_data <= 8'h00;
      air_tx_valid <= 1'b0;
      air_tx_eof <= 1'b0;
      p_d7 <= 1'b0;
      p_tog <= 1'b0;
      cont_arm <= 1'b0;
    end else begin
      state <= next_state;
      addr <= next_addr;
      rd <= next_rd;
      cont <= next_cont;
      mem <= next_mem;
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
      overflow <= next_overflow;
      irq_flags <= next_irq_flags;
      irq <= next_irq;
      clear_on_stop <= next_clear_on_stop;
      tx_len_high <= next_tx_len_high;
      tx_len_low <= next_tx_len_low;
      air_tx_active <= next_air_tx_active;
      tx_sent <= next_tx_sent;
      tx_long <= next_tx_long;
      rx_active <= next_rx_active;
      direct_mode <= next_direct_mode;
      ad_out <= next_ad_out;
      ad_oe <= next_ad_oe;
      air_tx_data <= next_air_tx_data;
      air_tx_valid <= next_air_tx_valid;
      air_tx_eof <= next_air_tx_eof;
      p_d7 <= s_d7;
      p_tog <= s_tog;
      cont_arm <= next_cont_arm;
    end
  end

  assign air_tx_broken = tx_len_low[3:0];

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  fifo_reset_a: assert property (fifo_clear |=> count == 4'h0 && !overflow)
    else $error("buffer not emptied by reset command");
  fill_field_a: assert property (count == 4'h8 |-> fill_state[3:0] == 4'h7)
    else $error("fill counter not stored bytes minus one");
  overflow_set_a: assert property (push_host && count == 4'hC && !fifo_clear |=> overflow)
    else $error("overflow flag missed on full buffer");
  high_level_a: assert property (air_rx_push && rx_active && !push_host && !pop_ok &&
      !fifo_clear && count == 4'h8 |=> fill_state[6])
    else $error("high level flag missing at nine bytes");
  tx_start_a: assert property (push_host && push_ok && !air_tx_active && !rx_active &&
      tx_total != 13'h0000 && !fifo_clear |=> air_tx_active && irq_flags[7])
    else $error("transmission did not start with first byte");
  eof_count_a: assert property (pop_tx && tx_sent + 13'h0001 == tx_total |=>
      air_tx_eof ##1 !air_tx_eof)
    else $error("end-of-frame not issued on last byte");
  rx_sof_a: assert property (air_rx_sof |=> irq_flags[6] && rx_active)
    else $error("start-of-frame cause bit not set");
  rx_ninth_a: assert property (air_rx_push && rx_active && !push_host && !fifo_clear &&
      count == 4'h8 |=> irq && irq_flags[5])
    else $error("ninth byte interrupt missing");
  rx_error_a: assert property (air_rx_crc_err |=> irq_flags[4])
    else $error("crc cause flag not set");
  start_port_a: assert property (start_cond |=> state == rfb_pkg::RFB_ADDR && !ad_oe)
    else $error("start condition did not reset port");
  stop_simple_a: assert property (simple_stop && !start_cond |=>
      state == rfb_pkg::RFB_IDLE && !direct_mode)
    else $error("simple stop did not end transaction");
  stop_cont_a: assert property (continuous_stop && !start_cond |=>
      state == rfb_pkg::RFB_IDLE [*2])
    else $error("continuous stop did not reset port");
endmodule
`default_nettype wire

// ===== rfb_pkg.sv
// Shared constants, types and register map of the reader data buffer block
package rfb_pkg;
  localparam int FIFO_DEPTH = 12;
  localparam logic [3:0] FIFO_LAST_PTR = 4'hB;
  localparam logic [3:0] FIFO_FULL_COUNT = 4'hC;
  localparam logic [3:0] FIFO_HIGH_COUNT = 4'h9;
  localparam logic [3:0] FIFO_REFILL_COUNT = 4'h3;

  // Register addresses
  localparam logic [4:0] ADDR_IRQ_CAUSE = 5'h0C;
  localparam logic [4:0] ADDR_FILL_STATE = 5'h1C;
  localparam logic [4:0] ADDR_TXLEN_HIGH = 5'h1D;
  localparam logic [4:0] ADDR_TXLEN_LOW = 5'h1E;
  localparam logic [4:0] ADDR_DATA_PORT = 5'h1F;

  // Command code that empties the buffer
  localparam logic [4:0] CMD_FIFO_RESET = 5'h0F;

  // Field positions in buffer_fill_state
  localparam int FILL_OVERFLOW_BIT = 4;
  localparam int FILL_LOW_BIT = 5;
  localparam int FILL_HIGH_BIT = 6;

  // Field positions in interrupt_cause_flags
  localparam int IRQ_TX_BIT = 7;
  localparam int IRQ_SOF_BIT = 6;
  localparam int IRQ_LEVEL_BIT = 5;
  localparam int IRQ_CRC_BIT = 4;
  localparam int IRQ_FRAME_BIT = 2;

  // Transmit thresholds in frame bytes
  localparam logic [12:0] TX_LOW_REMAIN = 13'h0003;
  localparam logic [12:0] TX_LONG_MIN = 13'h0005;

  // Reset values
  localparam logic [7:0] TXLEN_RESET = 8'h00;
  localparam logic [7:0] IRQ_CAUSE_RESET = 8'h00;
  localparam logic [7:0] PORT_OUT_RESET = 8'h00;

  typedef enum logic [1:0] {
    RFB_IDLE = 2'b00,
    RFB_ADDR = 2'b01,
    RFB_DATA = 2'b10
  } rfb_port_state_t;

  // Address or command word as sent by the host
  typedef struct packed {
    logic cmd;
    logic rd;
    logic cont;
    logic [4:0] code;
  } rfb_host_word_t;
endpackage

// ===== rfb_sync.sv
// Two-stage level synchroniser for signals entering the system clock domain
`timescale 1ns/1ns
`default_nettype none
module rfb_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk, // System clock
  input wire logic rst_n, // Asynchronous reset, active low
  input wire logic [WIDTH-1:0] d, // Asynchronous inputs
  output logic [WIDTH-1:0] q // Synchronised outputs
);
  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] next_meta;
  logic [WIDTH-1:0] next_q;

  always_comb begin
    next_meta = d;
    next_q = meta;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= next_meta;
      q <= next_q;
    end
  end
endmodule
`default_nettype wire

// ===== rfb_host_model.sv
// Host controller model driving the parallel register port of the buffer block
`timescale 1ns/1ns
`default_nettype none
module rfb_host_model #(
  parameter int HP = 203 // Strobe phase time; odd so it drifts against clk
) (
  output logic port_clk, // Host data strobe, still between frames
  output logic [7:0] pad, // Bus level at the pins
  input wire logic [7:0] ad_out, // Device read data
  input wire logic ad_oe // Device drive enable
);
  logic [7:0] hd;
  logic hoe;
  // An undriven bus shows the inverse of the last host value, so stale data never matches
  assign pad = hoe ? hd : (ad_oe ? ad_out : ~hd);
  initial begin
    port_clk = 1'b0;
    hd = 8'h00;
    hoe = 1'b1;
  end
  task automatic start();
    port_clk = 1'b0;
    #HP;
    hoe = 1'b1;
    hd = 8'h00;
    #HP;
    port_clk = 1'b1;
    #HP;
    hd[7] = 1'b1;
    #HP;
  endtask
  // Reads hand over the bus once the device drives, or after 200 ns without it, to avoid a floating delimiter
  task automatic word(input logic [7:0] w, input logic rel, output logic [7:0] d);
    port_clk = 1'b0;
    #HP;
    hoe = 1'b1;
    hd = w;
    #HP;
    port_clk = 1'b1;
    if (rel) begin
      for (int i = 0; i < 40 && !ad_oe; i++) #5;
      hoe = 1'b0;
    end
    #HP;
    d = pad;
  endtask
  task automatic cstop();
    port_clk = 1'b0;
    #HP;
    hoe = 1'b1;
    hd = 8'h00;
    #HP;
    hd[7] = 1'b1;
    #HP;
    hd[7] = 1'b0;
    #HP;
  endtask
  // Needs the strobe high and the delimiter high, as left by a command word
  task automatic sstop();
    hd[7] = 1'b0;
    #HP;
  endtask
endmodule
`default_nettype wire

// ===== tb_rfb_buffer.sv
// Self-checking testbench of the reader data buffer block
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) \
  begin checked++; if ((g) !== (e)) begin n_mismatch++; \
  $display("unexpected %s exp %h got %h", nm, e, g); end end
module tb_rfb_buffer;
  logic clk, rst_n, port_clk, ad_oe, irq, air_tx_pop, air_tx_valid, air_tx_active;
  logic air_tx_eof, air_rx_push, direct_mode;
  logic [7:0] pad, ad_out, air_tx_data, air_rx_data, d, f, b;
  logic [3:0] air_tx_broken;
  logic [4:0] ev;
  int checked = 0;
  int n_mismatch = 0;
  rfb_buffer i_dut (.clk(clk), .rst_n(rst_n), .port_clk(port_clk), .ad_in(pad),
    .ad_out(ad_out), .ad_oe(ad_oe), .irq(irq), .air_tx_pop(air_tx_pop),
    .air_tx_data(air_tx_data), .air_tx_valid(air_tx_valid), .air_tx_active(air_tx_active),
    .air_tx_eof(air_tx_eof), .air_tx_broken(air_tx_broken), .air_rx_sof(ev[4]),
    .air_rx_push(air_rx_push), .air_rx_data(air_rx_data), .air_rx_end(ev[3]),
    .air_rx_frame_err(ev[2]), .air_rx_crc_err(ev[1]), .direct_mode_enter(ev[0]),
    .direct_mode(direct_mode));
  rfb_host_model i_host (.port_clk(port_clk), .pad(pad), .ad_out(ad_out), .ad_oe(ad_oe));
  initial clk = 1'b0;
  always #10 clk = ~clk;
  task automatic end_sim();
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic rd(input logic [4:0] a);
    i_host.start();
    i_host.word({3'b010, a}, 1'b1, d);
    i_host.cstop();
  endtask
  task automatic chkrd(input string nm, input logic [4:0] a, input logic [7:0] e);
    rd(a);
    `CHK(nm, e, d)
  endtask
  task automatic clr();
    i_host.start();
    i_host.word({3'b100, rfb_pkg::CMD_FIFO_RESET}, 1'b0, d);
    i_host.sstop();
  endtask
  task automatic pop(input logic [7:0] e, input logic eof);
    @(negedge clk);
    air_tx_pop = 1'b1;
    @(negedge clk);
    air_tx_pop = 1'b0;
    // Valid and end-of-frame stand for one cycle only, so look right after the pop edge
    `CHK("tx_valid", 1'b1, air_tx_valid)
    `CHK("tx_data", e, air_tx_data)
    `CHK("tx_eof", eof, air_tx_eof)
  endtask
  task automatic rxp(input logic [7:0] v);
    @(negedge clk);
    air_rx_push = 1'b1;
    air_rx_data = v;
    @(negedge clk);
    air_rx_push = 1'b0;
    @(negedge clk);
  endtask
  task automatic evp(input logic [4:0] v);
    @(negedge clk);
    ev = v;
    @(negedge clk);
    ev = 5'h00;
    @(negedge clk);
  endtask
  // Generous bound: the whole sequence needs well under a tenth of this
  initial begin
    #2000000;
    n_mismatch++;
    end_sim();
  end
  initial begin
    rst_n = 1'b0;
    air_tx_pop = 1'b0;
    air_rx_push = 1'b0;
    air_rx_data = 8'h00;
    ev = 5'h00;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    `CHK("irq_reset", 1'b0, irq)
    `CHK("oe_reset", 1'b0, ad_oe)
    chkrd("fill_empty", rfb_pkg::ADDR_FILL_STATE, 8'h0F);
    chkrd("unmapped", 5'h05, 8'h00);
    i_host.start();
    i_host.word({3'b000, rfb_pkg::ADDR_IRQ_CAUSE}, 1'b0, d);
    i_host.word(8'hFF, 1'b0, d);
    i_host.cstop();
    chkrd("cause_ro", rfb_pkg::ADDR_IRQ_CAUSE, 8'h00);
    evp(5'b00001);
    `CHK("dm_on", 1'b1, direct_mode)
    clr();
    `CHK("dm_off", 1'b0, direct_mode)
    i_host.start();
    i_host.word(8'h3D, 1'b0, d);
    i_host.word(8'h00, 1'b0, d);
    i_host.word(8'h43, 1'b0, d);
    for (b = 8'hD0; b < 8'hD5; b++) i_host.word(b, 1'b0, d);
    i_host.cstop();
    `CHK("tx_active", 1'b1, air_tx_active)
    `CHK("tx_broken", 4'h3, air_tx_broken)
    `CHK("irq_idle", 1'b0, irq)
    chkrd("fill_five", rfb_pkg::ADDR_FILL_STATE, 8'h04);
    i_host.start();
    i_host.word(8'h7D, 1'b1, d);
    `CHK("len_high", 8'h00, d)
    i_host.word(d, 1'b1, d);
    `CHK("len_low", 8'h43, d)
    i_host.cstop();
    pop(8'hD0, 1'b0);
    pop(8'hD1, 1'b0);
    repeat (2) @(negedge clk);
    `CHK("irq_low", 1'b1, irq)
    chkrd("fill_low", rfb_pkg::ADDR_FILL_STATE, 8'h22);
    pop(8'hD2, 1'b0);
    pop(8'hD3, 1'b0);
    pop(8'hD4, 1'b1);
    `CHK("tx_done", 1'b0, air_tx_active)
    chkrd("cause_tx", rfb_pkg::ADDR_IRQ_CAUSE, 8'h80);
    repeat (4) @(negedge clk);
    `CHK("irq_clear", 1'b0, irq)
    chkrd("cause_clear", rfb_pkg::ADDR_IRQ_CAUSE, 8'h00);
    // Zero length keeps the transmitter idle while the buffer is overfilled
    i_host.start();
    i_host.word(8'h3D, 1'b0, d);
    i_host.word(8'h00, 1'b0, d);
    i_host.word(8'h00, 1'b0, d);
    for (b = 8'h00; b < 8'h0D; b++) i_host.word(b, 1'b0, d);
    i_host.cstop();
    rd(rfb_pkg::ADDR_FILL_STATE);
    `CHK("ovf_flag", 1'b1, d[4])
    `CHK("ovf_count", 4'hB, d[3:0])
    clr();
    rd(rfb_pkg::ADDR_FILL_STATE);
    `CHK("fifo_reset", 4'hF, d[3:0])
    evp(5'b10000);
    for (b = 8'hA0; b < 8'hA8; b++) rxp(b);
    `CHK("irq_eight", 1'b0, irq)
    rxp(8'hA8);
    `CHK("irq_nine", 1'b1, irq)
    rd(rfb_pkg::ADDR_FILL_STATE);
    `CHK("fill_high", 1'b1, d[6])
    `CHK("fill_nine", 4'h8, d[3:0])
    chkrd("cause_rx", rfb_pkg::ADDR_IRQ_CAUSE, 8'h60);
    repeat (4) @(negedge clk);
    `CHK("irq_rx_clear", 1'b0, irq)
    i_host.start();
    i_host.word(8'h7F, 1'b1, d);
    `CHK("rx_data", 8'hA0, d)
    for (b = 8'hA1; b < 8'hA9; b++) begin
      i_host.word(d, 1'b1, d);
      `CHK("rx_data", b, d)
    end
    i_host.cstop();
    evp(5'b00100);
    evp(5'b00010);
    evp(5'b01000);
    `CHK("irq_end", 1'b1, irq)
    rd(rfb_pkg::ADDR_IRQ_CAUSE);
    `CHK("cause_err", 8'h14, d & 8'h14)
    end_sim();
  end
endmodule
`default_nettype wire
